// *** verilog/ext_bus_dma_ctrl.sv ***
// Two-channel external bus DMA controller with APB register access
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ext_bus_dma_ctrl #(
	parameter int DATA_W = 16
) (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [ext_dma_pkg::CH_NUM-1:0] ext_xfer_request_n_i,
	output logic [ext_dma_pkg::CH_NUM-1:0] ext_xfer_acknowledge_n_o,
	output logic [ext_dma_pkg::CH_NUM-1:0] ext_xfer_end_pin_n_o,
	output logic [ext_dma_pkg::CH_NUM-1:0] request_accepted_pin_n_o,
	output logic [ext_dma_pkg::CH_NUM-1:0] irq_o,
	input wire logic [ext_dma_pkg::CH_NUM-1:0] abort_i,
	input wire logic nmi_i,
	input wire logic hw_standby_i,
	output logic [ext_dma_pkg::EXT_ADDR_W-1:0] ext_addr_o,
	output logic ext_rd_o,
	output logic ext_wr_o,
	output logic ext_word_o,
	output logic [DATA_W-1:0] ext_wdata_o,
	input wire logic [DATA_W-1:0] ext_rdata_i,
	input wire logic ext_ready_i
);
	import ext_dma_pkg::*;

	// Word transfers need at least a 16-bit data path
	if (DATA_W < 16)
		$error("DATA_W must be at least 16");

	// ==========================================================
	// Declarations
	bus_cycle_if cyc();

	logic [23:0] src_reg [CH_NUM];
	logic [23:0] dst_reg [CH_NUM];
	logic [23:0] cnt_reg [CH_NUM];
	logic [15:0] mode_reg [CH_NUM];
	logic [8:0] blk_left_reg [CH_NUM];
	logic eda_reg [CH_NUM];
	logic bef_reg [CH_NUM];
	logic irf_reg [CH_NUM];
	logic irf_seen_reg [CH_NUM];
	logic bef_seen_reg [CH_NUM];
	logic halt_req_reg [CH_NUM];
	logic in_block_reg [CH_NUM];
	logic [CH_NUM-1:0] accept_n_reg;
	logic [CH_NUM-1:0] ready;
	logic [CH_NUM-1:0] pending;
	logic [CH_NUM-1:0] start_ch;
	logic [CH_NUM-1:0] done_ch;
	logic [CH_NUM-1:0] last_ch;
	logic [CH_NUM-1:0] more_ch;
	logic [CH_NUM-1:0] consume;
	logic [CH_NUM-1:0] wr_src;
	logic [CH_NUM-1:0] wr_dst;
	logic [CH_NUM-1:0] wr_cnt;
	logic [CH_NUM-1:0] wr_mode;
	logic [CH_NUM-1:0] rd_mode;

	arb_state_e arb_reg;
	logic cur_reg;
	logic lock_reg;
	logic start_reg;
	logic [23:0] rd_addr_reg;
	logic [23:0] wr_addr_reg;
	logic dual_reg;
	logic dir_reg;
	logic word_reg;
	logic last_end_reg;
	logic pick;
	logic issue;
	logic acc_wr;
	logic acc_rd;
	logic mapped;
	logic addr_ch;
	logic [7:0] reg_off;

	// ==========================================================
	// APB decode; zero wait states, unmapped offsets answer with an error
	assign reg_off = paddr_i & ~CH_STRIDE;
	assign addr_ch = paddr_i[CH_SEL_BIT];
	assign mapped = (reg_off == OFF_SRC) || (reg_off == OFF_DST) ||
		(reg_off == OFF_CNT) || (reg_off == OFF_MODE);
	assign acc_wr = psel_i && penable_i && pwrite_i && mapped;
	assign acc_rd = psel_i && penable_i && !pwrite_i && mapped;
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i && !mapped;

	// Read data is captured in the setup phase so it comes from a flop
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
			prdata_o <= 32'h00000000;
		else if (psel_i && !penable_i && !pwrite_i)
		begin
			if (reg_off == OFF_SRC)
				prdata_o <= {8'h00, src_reg[addr_ch]};
			else if (reg_off == OFF_DST)
				prdata_o <= {8'h00, dst_reg[addr_ch]};
			else if (reg_off == OFF_CNT)
				prdata_o <= {8'h00, cnt_reg[addr_ch]};
			else if (reg_off == OFF_MODE)
				prdata_o <= {16'h0000, eda_reg[addr_ch], bef_reg[addr_ch],
					mode_reg[addr_ch][13:7], irf_reg[addr_ch], mode_reg[addr_ch][5:0]};
			else
				prdata_o <= 32'h00000000;
		end
	end

	// ==========================================================
	// Per-channel registers and control
	for (genvar c = 0; c < CH_NUM; c++)
	begin : g_ch
		logic is_block;
		logic is_ext;
		logic single;
		logic sdir;
		logic unit_last;
		logic count_end;
		logic halt_done;
		logic kill;
		logic [8:0] blk_size;
		logic [23:0] step;

		assign is_block = (mode_reg[c][BIT_OPMODE_HI:BIT_OPMODE_LO] == OP_EXT_BLOCK);
		assign is_ext = mode_reg[c][BIT_OPMODE_HI];
		assign single = mode_reg[c][BIT_ADDR_MODE];
		assign sdir = mode_reg[c][BIT_SDIR];
		assign step = mode_reg[c][BIT_SIZE] ? 24'h000002 : 24'h000001;
		assign wr_src[c] = acc_wr && addr_ch == 1'(c) && reg_off == OFF_SRC;
		assign wr_dst[c] = acc_wr && addr_ch == 1'(c) && reg_off == OFF_DST;
		assign wr_cnt[c] = acc_wr && addr_ch == 1'(c) && reg_off == OFF_CNT;
		assign wr_mode[c] = acc_wr && addr_ch == 1'(c) && reg_off == OFF_MODE;
		assign rd_mode[c] = acc_rd && addr_ch == 1'(c) && reg_off == OFF_MODE;
		assign done_ch[c] = cyc.done && cur_reg == 1'(c);
		assign start_ch[c] = issue && pick == 1'(c);

		// Block size field of zero stands for the largest block
		assign blk_size = (cnt_reg[c][23:16] == 8'h00) ? BLOCK_MAX : {1'b0, cnt_reg[c][23:16]};
		assign unit_last = in_block_reg[c] ? (blk_left_reg[c] == UNIT_ONE) : (blk_size == UNIT_ONE);
		// A zero count never reaches the last transfer, so it runs free
		assign last_ch[c] = is_block ? (cnt_reg[c][15:0] == BLK_CNT_ONE && unit_last)
			: (cnt_reg[c] == CNT_ONE);
		assign more_ch[c] = is_block && !unit_last;
		assign count_end = done_ch[c] && last_ch[c];
		assign halt_done = done_ch[c] && is_block && unit_last && halt_req_reg[c];
		assign kill = nmi_i || hw_standby_i || abort_i[c];

		// External mode waits for a request, except inside a started block
		assign ready[c] = eda_reg[c] && (!is_ext || in_block_reg[c] || pending[c]);
		assign consume[c] = start_ch[c] && is_ext && !in_block_reg[c];

		xfer_request_sense u_sense (
			.clock_i(clock_i),
			.sys_rst_i(sys_rst_i),
			.enable_i(eda_reg[c]),
			.req_n_i(ext_xfer_request_n_i[c]),
			.edge_mode_i(mode_reg[c][BIT_REQ_SENSE]),
			.consume_i(consume[c]),
			.pending_o(pending[c])
		);

		// Addresses advance by the unit size; the device side in single mode is skipped
		always_ff @(posedge clock_i)
		begin
			if (sys_rst_i)
			begin
				src_reg[c] <= ADDR_RESET;
				dst_reg[c] <= ADDR_RESET;
			end
			else
			begin
				if (wr_src[c])
					src_reg[c] <= pwdata_i[23:0];
				else if (done_ch[c] && (!single || !sdir))
					src_reg[c] <= src_reg[c] + step;
				if (wr_dst[c])
					dst_reg[c] <= pwdata_i[23:0];
				else if (done_ch[c] && (!single || sdir))
					dst_reg[c] <= dst_reg[c] + step;
			end
		end

		// Counters; block transfers never touch the block size field, other modes count down all 24 bits
		always_ff @(posedge clock_i)
		begin
			if (sys_rst_i)
			begin
				cnt_reg[c] <= CNT_RESET;
				blk_left_reg[c] <= UNIT_ONE;
				in_block_reg[c] <= 1'b0;
			end
			else if (wr_cnt[c])
				cnt_reg[c] <= pwdata_i[23:0];
			else if (nmi_i)
				in_block_reg[c] <= 1'b0;
			else if (start_ch[c] && is_block && !in_block_reg[c])
			begin
				blk_left_reg[c] <= blk_size;
				in_block_reg[c] <= 1'b1;
			end
			else if (done_ch[c])
			begin
				if (is_block)
				begin
					blk_left_reg[c] <= blk_left_reg[c] - UNIT_ONE;
					if (unit_last)
					begin
						in_block_reg[c] <= 1'b0;
						if (cnt_reg[c][15:0] != 16'h0000)
							cnt_reg[c][15:0] <= cnt_reg[c][15:0] - 16'h0001;
					end
				end
				else if (cnt_reg[c] != CNT_RESET)
					cnt_reg[c] <= cnt_reg[c] - CNT_ONE;
			end
		end

		// Active bit, halt request and mode fields
		always_ff @(posedge clock_i)
		begin
			if (sys_rst_i)
			begin
				eda_reg[c] <= 1'b0;
				halt_req_reg[c] <= 1'b0;
				mode_reg[c] <= MODE_RESET;
			end
			else
			begin
				if (wr_mode[c])
					mode_reg[c] <= pwdata_i[15:0] & MODE_WR_MASK;
				if (kill || count_end || halt_done)
				begin
					eda_reg[c] <= 1'b0;
					halt_req_reg[c] <= 1'b0;
				end
				else if (wr_mode[c] && pwdata_i[BIT_ACTIVE] && !eda_reg[c])
					eda_reg[c] <= 1'b1;
				else if (wr_mode[c] && !pwdata_i[BIT_ACTIVE] && eda_reg[c])
				begin
					// A block in flight is finished before the channel stops
					if (is_block && in_block_reg[c])
						halt_req_reg[c] <= 1'b1;
					else
						eda_reg[c] <= 1'b0;
				end
			end
		end

		// Sticky flags; a hardware set beats a software clear in the same cycle
		always_ff @(posedge clock_i)
		begin
			if (sys_rst_i)
			begin
				irf_reg[c] <= 1'b0;
				irf_seen_reg[c] <= 1'b0;
				bef_reg[c] <= 1'b0;
				bef_seen_reg[c] <= 1'b0;
			end
			else
			begin
				if (count_end && mode_reg[c][BIT_TCEIE])
					irf_reg[c] <= 1'b1;
				else if (wr_mode[c] && ((pwdata_i[BIT_ACTIVE] && !eda_reg[c]) ||
					(!pwdata_i[BIT_IRF] && irf_seen_reg[c])))
					irf_reg[c] <= 1'b0;
				if (nmi_i && eda_reg[c] && in_block_reg[c])
					bef_reg[c] <= 1'b1;
				else if (wr_mode[c] && !pwdata_i[BIT_BEF] && bef_seen_reg[c])
					bef_reg[c] <= 1'b0;
				if (wr_mode[c])
				begin
					irf_seen_reg[c] <= 1'b0;
					bef_seen_reg[c] <= 1'b0;
				end
				else if (rd_mode[c])
				begin
					irf_seen_reg[c] <= irf_reg[c];
					bef_seen_reg[c] <= bef_reg[c];
				end
			end
		end

		// Acceptance pulse when a request is taken and its transfer begins
		always_ff @(posedge clock_i)
		begin
			if (sys_rst_i)
				accept_n_reg[c] <= 1'b1;
			else
				accept_n_reg[c] <= !(consume[c] && mode_reg[c][BIT_ACCEPT_EN]);
		end

		assign irq_o[c] = irf_reg[c] && mode_reg[c][BIT_IRQ_EN];
	end

	// ==========================================================
	// Arbitration: a locked burst or block keeps the bus, else channel 2 wins
	assign pick = (lock_reg && ready[cur_reg]) ? cur_reg : !ready[0];
	assign issue = (arb_reg == ARB_IDLE) && (|ready) && !nmi_i && !hw_standby_i;

	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
		begin
			arb_reg <= ARB_IDLE;
			cur_reg <= 1'b0;
			lock_reg <= 1'b0;
			start_reg <= 1'b0;
		end
		else
		begin
			start_reg <= 1'b0;
			unique case (arb_reg)
				ARB_IDLE:
					if (issue)
					begin
						arb_reg <= ARB_RUN;
						cur_reg <= pick;
						start_reg <= 1'b1;
					end
				ARB_RUN:
					if (cyc.done)
					begin
						// Cycle steal always reopens arbitration between transfers
						arb_reg <= ARB_IDLE;
						lock_reg <= more_ch[cur_reg] || (mode_reg[cur_reg][BIT_OPMODE_HI:BIT_OPMODE_LO]
							== OP_AUTO_BURST);
					end
			endcase
		end
	end

	// Transfer attributes sampled from the chosen channel at issue
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
		begin
			rd_addr_reg <= ADDR_RESET;
			wr_addr_reg <= ADDR_RESET;
			dual_reg <= 1'b1;
			dir_reg <= 1'b0;
			word_reg <= 1'b0;
			last_end_reg <= 1'b0;
		end
		else if (issue)
		begin
			rd_addr_reg <= src_reg[pick];
			wr_addr_reg <= dst_reg[pick];
			dual_reg <= !mode_reg[pick][BIT_ADDR_MODE];
			dir_reg <= mode_reg[pick][BIT_SDIR];
			word_reg <= mode_reg[pick][BIT_SIZE];
			last_end_reg <= last_ch[pick] && mode_reg[pick][BIT_END_EN];
		end
	end

	assign cyc.start = start_reg;
	assign cyc.rd_addr = rd_addr_reg;
	assign cyc.wr_addr = wr_addr_reg;
	assign cyc.dual = dual_reg;
	assign cyc.dev_to_mem = dir_reg;
	assign cyc.word = word_reg;
	assign cyc.last_end = last_end_reg;
	assign cyc.chan = cur_reg;

	// ==========================================================
	// Bus engine and channel pins
	bus_cycle_engine #(
		.DATA_W(DATA_W)
	) u_engine (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.cyc(cyc),
		.ext_addr_o(ext_addr_o),
		.ext_rd_o(ext_rd_o),
		.ext_wr_o(ext_wr_o),
		.ext_word_o(ext_word_o),
		.ext_wdata_o(ext_wdata_o),
		.ext_rdata_i(ext_rdata_i),
		.ext_ready_i(ext_ready_i)
	);

	assign ext_xfer_acknowledge_n_o = cyc.ack_n;
	assign ext_xfer_end_pin_n_o = cyc.end_n;
	assign request_accepted_pin_n_o = accept_n_reg;

endmodule : ext_bus_dma_ctrl
`default_nettype wire

// *** verilog/ext_dma_pkg.sv ***
// Shared constants and types of the two-channel external bus DMA controller
package ext_dma_pkg;

	// ==========================================================
	// Structure
	localparam int CH_NUM = 2;
	localparam int EXT_ADDR_W = 24;

	// ==========================================================
	// Register map: per-channel byte offsets, channel 3 sits one stride above channel 2
	localparam logic [7:0] OFF_SRC = 8'h00;
	localparam logic [7:0] OFF_DST = 8'h04;
	localparam logic [7:0] OFF_CNT = 8'h08;
	localparam logic [7:0] OFF_MODE = 8'h0c;
	localparam logic [7:0] CH_STRIDE = 8'h10;
	localparam int CH_SEL_BIT = 4;

	// ==========================================================
	// Mode control fields
	localparam int BIT_ACTIVE = 15;
	localparam int BIT_BEF = 14;
	localparam int BIT_ACCEPT_EN = 13;
	localparam int BIT_END_EN = 12;
	localparam int BIT_REQ_SENSE = 11;
	localparam int BIT_ADDR_MODE = 10;
	localparam int BIT_OPMODE_HI = 9;
	localparam int BIT_OPMODE_LO = 8;
	localparam int BIT_IRQ_EN = 7;
	localparam int BIT_IRF = 6;
	localparam int BIT_TCEIE = 5;
	localparam int BIT_SDIR = 4;
	localparam int BIT_SIZE = 3;
	localparam logic [15:0] MODE_WR_MASK = 16'h3fbc;
	localparam logic [15:0] MODE_RESET = 16'h0000;

	// ==========================================================
	// Count fields and reset values
	localparam int CNT_BLK_LSB = 16;
	localparam logic [23:0] ADDR_RESET = 24'h000000;
	localparam logic [23:0] CNT_RESET = 24'h000000;
	localparam logic [23:0] CNT_ONE = 24'h000001;
	localparam logic [15:0] BLK_CNT_ONE = 16'h0001;
	localparam logic [8:0] BLOCK_MAX = 9'h100;
	localparam logic [8:0] UNIT_ONE = 9'h001;

	// ==========================================================
	// Enumerations
	typedef enum logic [1:0] {
		OP_AUTO_STEAL = 2'h0,
		OP_AUTO_BURST = 2'h1,
		OP_EXT_STEAL = 2'h2,
		OP_EXT_BLOCK = 2'h3
	} op_mode_e;

	typedef enum logic [1:0] {
		ENG_IDLE = 2'h0,
		ENG_READ = 2'h1,
		ENG_WRITE = 2'h2
	} engine_state_e;

	typedef enum logic [1:0] {
		SENSE_OFF = 2'h0,
		SENSE_WAIT_LOW = 2'h1,
		SENSE_PENDING = 2'h2,
		SENSE_WAIT_HIGH = 2'h3
	} sense_state_e;

	typedef enum logic {
		ARB_IDLE = 1'b0,
		ARB_RUN = 1'b1
	} arb_state_e;

endpackage : ext_dma_pkg

// *** verilog/bus_cycle_if.sv ***
// Link between the channel controller and the external bus cycle engine
`timescale 1ns/1ps
`default_nettype none
interface bus_cycle_if;
	logic start;
	logic [23:0] rd_addr;
	logic [23:0] wr_addr;
	logic dual;
	logic dev_to_mem;
	logic word;
	logic last_end;
	logic chan;
	logic done;
	logic [1:0] ack_n;
	logic [1:0] end_n;

	modport ctrl (
		output start, rd_addr, wr_addr, dual, dev_to_mem, word, last_end, chan,
		input done, ack_n, end_n
	);
	modport engine (
		input start, rd_addr, wr_addr, dual, dev_to_mem, word, last_end, chan,
		output done, ack_n, end_n
	);
endinterface : bus_cycle_if
`default_nettype wire

// *** verilog/xfer_request_sense.sv ***
// External request sampler for one channel: level or falling-edge sensing
`timescale 1ns/1ps
`default_nettype none
module xfer_request_sense (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic enable_i,
	input wire logic req_n_i,
	input wire logic edge_mode_i,
	input wire logic consume_i,
	output logic pending_o
);
	import ext_dma_pkg::*;

	sense_state_e state_reg;

	// ==========================================================
	// Sense state machine; entering from OFF always waits for a low level
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i || !enable_i)
			state_reg <= SENSE_OFF;
		else
		begin
			unique case (state_reg)
				SENSE_OFF: state_reg <= SENSE_WAIT_LOW;
				SENSE_WAIT_LOW:
					if (!req_n_i)
						state_reg <= SENSE_PENDING;
				SENSE_PENDING:
					if (consume_i)
						state_reg <= edge_mode_i ? SENSE_WAIT_HIGH : SENSE_WAIT_LOW;
				SENSE_WAIT_HIGH:
					if (req_n_i)
						state_reg <= SENSE_WAIT_LOW;
			endcase
		end
	end

	// Pending only after the low level was seen in the armed state
	assign pending_o = (state_reg == SENSE_PENDING);

endmodule : xfer_request_sense
`default_nettype wire

// *** verilog/bus_cycle_engine.sv ***
// External bus cycle engine: one read and/or one write per transfer
`timescale 1ns/1ps
`default_nettype none
module bus_cycle_engine #(
	parameter int DATA_W = 16
) (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	bus_cycle_if.engine cyc,
	output logic [ext_dma_pkg::EXT_ADDR_W-1:0] ext_addr_o,
	output logic ext_rd_o,
	output logic ext_wr_o,
	output logic ext_word_o,
	output logic [DATA_W-1:0] ext_wdata_o,
	input wire logic [DATA_W-1:0] ext_rdata_i,
	input wire logic ext_ready_i
);
	import ext_dma_pkg::*;

	engine_state_e state_reg;
	logic [23:0] wr_addr_reg;
	logic dual_reg;
	logic chan_reg;
	logic last_end_reg;
	logic done_reg;
	logic final_phase;

	// ==========================================================
	// Cycle sequencing; strobes stay up until the target answers ready
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
		begin
			state_reg <= ENG_IDLE;
			ext_rd_o <= 1'b0;
			ext_wr_o <= 1'b0;
			ext_addr_o <= ADDR_RESET;
			done_reg <= 1'b0;
		end
		else
		begin
			done_reg <= 1'b0;
			unique case (state_reg)
				ENG_IDLE:
					if (cyc.start)
					begin
						// Single mode uses only the memory-side address
						if (cyc.dual || !cyc.dev_to_mem)
						begin
							state_reg <= ENG_READ;
							ext_rd_o <= 1'b1;
							ext_addr_o <= cyc.rd_addr;
						end
						else
						begin
							state_reg <= ENG_WRITE;
							ext_wr_o <= 1'b1;
							ext_addr_o <= cyc.wr_addr;
						end
					end
				ENG_READ:
					if (ext_ready_i)
					begin
						ext_rd_o <= 1'b0;
						if (dual_reg)
						begin
							state_reg <= ENG_WRITE;
							ext_wr_o <= 1'b1;
							ext_addr_o <= wr_addr_reg;
						end
						else
						begin
							state_reg <= ENG_IDLE;
							done_reg <= 1'b1;
						end
					end
				ENG_WRITE:
					if (ext_ready_i)
					begin
						ext_wr_o <= 1'b0;
						state_reg <= ENG_IDLE;
						done_reg <= 1'b1;
					end
				default: state_reg <= ENG_IDLE;
			endcase
		end
	end

	// Transfer attributes held for the whole transfer
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
		begin
			wr_addr_reg <= ADDR_RESET;
			dual_reg <= 1'b0;
			chan_reg <= 1'b0;
			last_end_reg <= 1'b0;
			ext_word_o <= 1'b0;
		end
		else if (state_reg == ENG_IDLE && cyc.start)
		begin
			wr_addr_reg <= cyc.wr_addr;
			dual_reg <= cyc.dual;
			chan_reg <= cyc.chan;
			last_end_reg <= cyc.last_end;
			ext_word_o <= cyc.word;
		end
	end

	// Read data is parked here for the write half of a dual transfer
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
			ext_wdata_o <= '0;
		else if (state_reg == ENG_READ && ext_ready_i)
			ext_wdata_o <= ext_rdata_i;
	end

	// ==========================================================
	// Channel pins follow the cycle state; end marks only the closing bus cycle
	assign final_phase = dual_reg ? (state_reg == ENG_WRITE) : (state_reg != ENG_IDLE);
	for (genvar c = 0; c < CH_NUM; c++)
	begin : g_pins
		assign cyc.ack_n[c] = !(state_reg != ENG_IDLE && !dual_reg && chan_reg == 1'(c));
		assign cyc.end_n[c] = !(final_phase && last_end_reg && chan_reg == 1'(c));
	end
	assign cyc.done = done_reg;

endmodule : bus_cycle_engine
`default_nettype wire

// *** bench/ext_mem_model.sv ***
// Partner model: external memory answering the DMA bus cycles
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
	input wire logic clock_i,
	input wire logic [23:0] ext_addr_o,
	input wire logic ext_rd_o,
	input wire logic ext_wr_o,
	input wire logic [15:0] ext_wdata_o,
	input wire logic [3:0] slow_i,
	output logic [15:0] mem_rdata_o,
	output logic mem_ready_o,
	output logic [23:0] last_wa_o,
	output logic [15:0] last_wd_o
);
	logic [3:0] wait_cnt;
	logic strobe;
	// Data is a pattern of the address; a released bus shows its inverse, never a stale value
	assign strobe = ext_rd_o || ext_wr_o;
	assign mem_rdata_o = ext_rd_o ? ext_addr_o[15:0] ^ 16'h5a5a : ~(ext_addr_o[15:0] ^ 16'h5a5a);
	// Ready after slow_i wait cycles, one cycle wide; the last write is kept for the bench
	always_ff @(posedge clock_i)
	begin
		wait_cnt <= (strobe && !mem_ready_o) ? wait_cnt + 4'h1 : 4'h0;
		mem_ready_o <= strobe && !mem_ready_o && wait_cnt >= slow_i;
		if (ext_wr_o && mem_ready_o)
			last_wa_o <= ext_addr_o;
		if (ext_wr_o && mem_ready_o)
			last_wd_o <= ext_wdata_o;
	end
endmodule : ext_mem_model
`default_nettype wire

// *** bench/ext_dma_chk.sv ***
// Concurrent checks on the ports of the external bus DMA controller
`timescale 1ns/1ps
`default_nettype none
module ext_dma_chk (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic [31:0] prdata_o,
	input wire logic pslverr_o,
	input wire logic [1:0] ext_xfer_acknowledge_n_o,
	input wire logic [1:0] ext_xfer_end_pin_n_o,
	input wire logic [1:0] request_accepted_pin_n_o,
	input wire logic [1:0] irq_o,
	input wire logic [23:0] ext_addr_o,
	input wire logic ext_rd_o,
	input wire logic ext_wr_o,
	input wire logic ext_ready_i
);
	import ext_dma_pkg::*;
	// ==========================================================
	// Bus cycle waiting for the far side
	default clocking @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	sequence s_wait;
		(ext_rd_o || ext_wr_o) && !ext_ready_i;
	endsequence
	// ==========================================================
	// Assertions
	chk_top_zero: assert property (prdata_o[31:24] == 8'h00)
		else $error("Top byte of read data not zero");
	chk_unmapped_err: assert property (psel_i && penable_i && paddr_i >= 8'h20 |-> pslverr_o)
		else $error("Unmapped access without error");
	chk_mapped_ok: assert property (psel_i && penable_i && paddr_i < 8'h20 |-> !pslverr_o)
		else $error("Mapped access flagged as error");
	chk_accept_pulse: assert property ((~request_accepted_pin_n_o & ~$past(request_accepted_pin_n_o)) == 2'h0)
		else $error("Accepted pin low for two cycles");
	chk_one_ack: assert property ($onehot0(~ext_xfer_acknowledge_n_o))
		else $error("Both channels acknowledged at once");
	chk_rdwr_excl: assert property (!(ext_rd_o && ext_wr_o))
		else $error("Read and write strobes together");
	chk_strobe_hold: assert property (s_wait |=> $stable({ext_rd_o, ext_wr_o, ext_addr_o}))
		else $error("Bus cycle changed before ready");
	chk_reset_quiet: assert property ($fell(sys_rst_i) |-> &ext_xfer_acknowledge_n_o && &ext_xfer_end_pin_n_o
		&& &request_accepted_pin_n_o && irq_o == 2'h0 && !ext_rd_o && !ext_wr_o)
		else $error("Outputs not idle after reset");
endmodule : ext_dma_chk
bind ext_bus_dma_ctrl ext_dma_chk ext_dma_chk_inst (.*);
`default_nettype wire

// *** bench/tb.sv ***
// Self-checking bench of the two-channel external bus DMA controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
	$display("Error at %0t got %h expected %h", $time, a, b); end end
module tb;
	import ext_dma_pkg::*;
	logic clock_i, sys_rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, nmi_i, hw_standby_i;
	logic ext_rd_o, ext_wr_o, ext_word_o, ext_ready_i, err;
	logic [7:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic [1:0] ext_xfer_request_n_i, ext_xfer_acknowledge_n_o, ext_xfer_end_pin_n_o;
	logic [1:0] request_accepted_pin_n_o, irq_o, abort_i;
	logic [23:0] ext_addr_o, last_wa;
	logic [15:0] ext_wdata_o, ext_rdata_i, last_wd;
	logic [3:0] slow, saw;
	logic saw_clr;
	int fail_count, compares;
	ext_bus_dma_ctrl ext_bus_dma_ctrl_inst (.*);
	ext_mem_model ext_mem_model_inst (.*, .slow_i(slow), .mem_rdata_o(ext_rdata_i),
		.mem_ready_o(ext_ready_i), .last_wa_o(last_wa), .last_wd_o(last_wd));
	// ==========================================================
	// Clock and pin watch: remembers which pins went low since last cleared
	initial
	begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end
	// Cleared in reset so the unknown pins before the first edge never stick
	always @(posedge clock_i)
		saw <= (sys_rst_i || saw_clr) ? 4'h0 : saw | {~ext_xfer_end_pin_n_o[1],
			~request_accepted_pin_n_o[1], ~ext_xfer_acknowledge_n_o[1],
			~ext_xfer_end_pin_n_o[0]};
	// ==========================================================
	// Bus tasks
	task automatic close_out;
		if (fail_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out
	// One APB transfer, held until pready is seen; an idle cycle follows
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clock_i);
		penable_i <= 1'b1;
		do
		begin
			@(posedge clock_i);
			n++;
		end
		while (pready_o !== 1'b1 && n < 20);
		if (pready_o !== 1'b1)
		begin
			fail_count++;
			close_out;
		end
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clock_i);
	endtask : apb
	// Polls a mode register until the channel goes inactive
	task automatic idle(input logic [7:0] a);
		for (int i = 0; i < 200; i++)
		begin
			apb(1'b0, a, 32'h0);
			if (rd[15] === 1'b0)
				return;
		end
		fail_count++;
		close_out;
	endtask : idle
	// ==========================================================
	// Scenarios
	task automatic t_regs;
		apb(1'b0, 8'h0c, 32'h0);
		`CHK(rd, 32'h0)
		apb(1'b1, 8'h14, 32'hffffffff);
		apb(1'b0, 8'h14, 32'h0);
		`CHK(rd, 32'h00ffffff)
		apb(1'b0, 8'h20, 32'h0);
		`CHK(err, 1'b1)
	endtask : t_regs
	// Dual address auto request, two words, end pin and count-end interrupt
	task automatic t_dual;
		apb(1'b1, 8'h00, 32'h100);
		apb(1'b1, 8'h04, 32'h200);
		apb(1'b1, 8'h08, 32'h2);
		apb(1'b1, 8'h0c, 32'h90a8);
		idle(8'h0c);
		`CHK(irq_o[0], 1'b1)
		`CHK({saw[0], ext_word_o, last_wa, last_wd}, {1'b1, 1'b1, 24'h202, 16'h5b58})
		apb(1'b0, 8'h00, 32'h0);
		`CHK(rd, 32'h104)
		apb(1'b0, 8'h08, 32'h0);
		`CHK(rd, 32'h0)
		apb(1'b1, 8'h0c, 32'h80);
		`CHK(irq_o[0], 1'b0)
	endtask : t_dual
	// Channel 3 single address, external request held off then given
	task automatic t_ext;
		saw_clr <= 1'b1;
		apb(1'b1, 8'h10, 32'h300);
		saw_clr <= 1'b0;
		apb(1'b1, 8'h18, 32'h1);
		apb(1'b1, 8'h1c, 32'ha600);
		apb(1'b0, 8'h18, 32'h0);
		`CHK(rd, 32'h1)
		ext_xfer_request_n_i <= 2'h1;
		idle(8'h1c);
		ext_xfer_request_n_i <= 2'h3;
		`CHK(saw[3:1], 3'h3)
		apb(1'b0, 8'h10, 32'h0);
		`CHK(rd, 32'h301)
	endtask : t_ext
	// Non-maskable interrupt in the middle of a block on a slow memory
	task automatic t_nmi;
		apb(1'b1, 8'h08, 32'h40002);
		apb(1'b1, 8'h0c, 32'h8300);
		slow <= 4'h3;
		ext_xfer_request_n_i <= 2'h2;
		for (int i = 0; i < 50 && ext_rd_o !== 1'b1; i++)
			@(posedge clock_i);
		// A block that never starts is a hang, not a pass
		if (ext_rd_o !== 1'b1)
		begin
			fail_count++;
			close_out;
		end
		nmi_i <= 1'b1;
		@(posedge clock_i);
		nmi_i <= 1'b0;
		ext_xfer_request_n_i <= 2'h3;
		idle(8'h0c);
		`CHK(rd[14], 1'b1)
		apb(1'b0, 8'h08, 32'h0);
		`CHK(rd[23:16], 8'h04)
		apb(1'b1, 8'h0c, 32'h0);
		apb(1'b0, 8'h0c, 32'h0);
		`CHK(rd[14], 1'b0)
	endtask : t_nmi
	// Channel 3 single address burst into memory, then a free run cut by abort
	task automatic t_burst;
		apb(1'b1, 8'h14, 32'h400);
		apb(1'b1, 8'h18, 32'h2);
		apb(1'b1, 8'h1c, 32'h8510);
		idle(8'h1c);
		apb(1'b0, 8'h14, 32'h0);
		`CHK({rd, last_wa}, {32'h402, 24'h401})
		apb(1'b1, 8'h18, 32'h0);
		apb(1'b1, 8'h1c, 32'h8510);
		abort_i <= 2'h2;
		idle(8'h1c);
		abort_i <= 2'h0;
		apb(1'b0, 8'h18, 32'h0);
		`CHK(rd, 32'h0)
	endtask : t_burst
	// ==========================================================
	// Main sequence
	initial
	begin
		{sys_rst_i, psel_i, penable_i, pwrite_i, nmi_i, hw_standby_i} = 6'h20;
		{paddr_i, pwdata_i, abort_i, slow, saw_clr} = '0;
		ext_xfer_request_n_i = 2'h3;
		fail_count = 0;
		compares = 0;
		repeat (5) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		t_regs;
		t_dual;
		t_ext;
		t_nmi;
		t_burst;
		close_out;
	end
endmodule : tb
`default_nettype wire
